// File: common/fcd_consts.svh
// Port offsets, field positions, reset values and cycle counts of the DMA channel block
`ifndef FCD_CONSTS_SVH
`define FCD_CONSTS_SVH

// ****************************************************************
// Port offsets within the controller's sixteen byte ports
// ****************************************************************
`define FCD_PORT_STATUS       4'h8
`define FCD_PORT_COMMAND      4'h8
`define FCD_PORT_SOFT_REQ     4'h9
`define FCD_PORT_SINGLE_MASK  4'hA
`define FCD_PORT_MODE         4'hB
`define FCD_PORT_PTR_CLEAR    4'hC
`define FCD_PORT_MASTER_CLEAR 4'hD
`define FCD_PORT_SCRATCH      4'hD
`define FCD_PORT_MASK_CLEAR   4'hE
`define FCD_PORT_ALL_MASK     4'hF

// ****************************************************************
// Command register field positions
// ****************************************************************
`define FCD_CMD_MEM_COPY      0
`define FCD_CMD_ADDR_HOLD     1
`define FCD_CMD_DISABLE       2
`define FCD_CMD_SHORT_CYCLE   3
`define FCD_CMD_ROTATE        4
`define FCD_CMD_LATE_WRITE    5
`define FCD_CMD_DREQ_LOW      6
`define FCD_CMD_DACK_HIGH     7

// ****************************************************************
// Mask and mode port field positions
// ****************************************************************
`define FCD_MASK_VALUE_BIT    2
`define FCD_MODE_FIELD_LSB    2

// ****************************************************************
// Reset values
// ****************************************************************
`define FCD_RST_MASK          4'hF
`define FCD_RST_COMMAND       8'h00
`define FCD_RST_DACK_IDLE     4'hF

// ****************************************************************
// Clock cycles per transfer for normal and compressed timing
// ****************************************************************
`define FCD_CYC_NORMAL        2'h2
`define FCD_CYC_SHORT         2'h1

`endif

// File: common/fcd_pkg.sv
// Types shared by the DMA channel block
package fcd_pkg;

	// ****************************************************************
	// Transfer kind, mode bits 7-6
	// ****************************************************************
	typedef enum logic [1:0] {
		FCD_KIND_DEMAND  = 2'h0,
		FCD_KIND_SINGLE  = 2'h1,
		FCD_KIND_BLOCK   = 2'h2,
		FCD_KIND_CASCADE = 2'h3
	} fcd_kind_e;

	// ****************************************************************
	// Operation kind, mode bits 3-2
	// ****************************************************************
	typedef enum logic [1:0] {
		FCD_OP_VERIFY = 2'h0,
		FCD_OP_WRITE  = 2'h1,
		FCD_OP_READ   = 2'h2,
		FCD_OP_RSVD   = 2'h3
	} fcd_op_e;

	// ****************************************************************
	// Engine states
	// ****************************************************************
	typedef enum logic [1:0] {
		FCD_ST_IDLE,
		FCD_ST_XFER
	} fcd_state_e;

	// Stored mode bits 7-2 of one channel
	typedef logic [5:0] fcd_mode_t;

endpackage

// File: verilog/fcd_chan.sv
// One DMA channel: base and current address and count, and its stored mode
`include "fcd_consts.svh"

module fcd_chan (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire logic              wr_addr,
	input  wire logic              wr_count,
	input  wire logic              byte_hi,
	input  wire logic [7:0]        wdata,
	input  wire logic              mode_wr,
	input  wire fcd_pkg::fcd_mode_t mode_data,
	input  wire logic              step,
	input  wire logic              hold,
	output logic [15:0]            cur_addr,
	output logic [15:0]            cur_count,
	output fcd_pkg::fcd_mode_t     mode,
	output logic                   last
);

	logic [15:0]        base_addr_ff, nxt_base_addr;
	logic [15:0]        base_cnt_ff, nxt_base_cnt;
	logic [15:0]        addr_ff, nxt_addr;
	logic [15:0]        cnt_ff, nxt_cnt;
	fcd_pkg::fcd_mode_t mode_ff, nxt_mode;
	logic               dec;
	logic               auto_reload;

	assign dec         = mode_ff[3];
	assign auto_reload = mode_ff[2];
	assign cur_addr    = addr_ff;
	assign cur_count   = cnt_ff;
	assign mode        = mode_ff;
	// Count runs N+1 transfers, so the last one is taken at zero
	assign last        = (cnt_ff == 16'h0000);

	// ****************************************************************
	// Byte loads, per-transfer stepping and reload at the run's end
	// ****************************************************************
	always_comb begin
		nxt_base_addr = base_addr_ff;
		nxt_base_cnt  = base_cnt_ff;
		nxt_addr      = addr_ff;
		nxt_cnt       = cnt_ff;
		nxt_mode      = mode_ff;
		if (mode_wr) begin
			nxt_mode = mode_data;
		end
		if (step) begin
			if (last && auto_reload) begin
				nxt_addr = base_addr_ff;
				nxt_cnt  = base_cnt_ff;
			end else begin
				nxt_cnt = cnt_ff - 16'h0001;
				if (!hold) begin
					nxt_addr = dec ? addr_ff - 16'h0001 : addr_ff + 16'h0001;
				end
			end
		end
		// Software load wins over a step in the same cycle
		if (wr_addr) begin
			if (byte_hi) begin
				nxt_base_addr[15:8] = wdata;
				nxt_addr[15:8]      = wdata;
			end else begin
				nxt_base_addr[7:0] = wdata;
				nxt_addr[7:0]      = wdata;
			end
		end
		if (wr_count) begin
			if (byte_hi) begin
				nxt_base_cnt[15:8] = wdata;
				nxt_cnt[15:8]      = wdata;
			end else begin
				nxt_base_cnt[7:0] = wdata;
				nxt_cnt[7:0]      = wdata;
			end
		end
	end

	// Channel registers; held while the clock enable is low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			base_addr_ff <= 16'h0000;
			base_cnt_ff  <= 16'h0000;
			addr_ff      <= 16'h0000;
			cnt_ff       <= 16'h0000;
			mode_ff      <= 6'h00;
		end else if (ce) begin
			base_addr_ff <= nxt_base_addr;
			base_cnt_ff  <= nxt_base_cnt;
			addr_ff      <= nxt_addr;
			cnt_ff       <= nxt_cnt;
			mode_ff      <= nxt_mode;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n || !ce);

	chk_mode_store: assert property (mode_wr |=> mode_ff == $past(mode_data))
		else $error("mode bits not stored");
	chk_addr_up: assert property (step && !last && !hold && !dec && !wr_addr
		|=> addr_ff == $past(addr_ff) + 16'h0001)
		else $error("address did not increment");
	chk_addr_down: assert property (step && !last && !hold && dec && !wr_addr
		|=> addr_ff == $past(addr_ff) - 16'h0001)
		else $error("address did not decrement");
	chk_auto_reload: assert property (step && last && auto_reload && !wr_addr && !wr_count
		|=> addr_ff == $past(base_addr_ff) && cnt_ff == $past(base_cnt_ff))
		else $error("auto reload missed");

endmodule

// File: verilog/fcd_top.sv
// Four-channel DMA controller: byte ports, masks, modes, status and transfer engine
`include "fcd_consts.svh"

module fcd_top (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [3:0]  io_addr,
	input  wire logic [7:0]  io_wdata,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [3:0]  dreq,
	input  wire logic [9:0]  page_ch0,
	input  wire logic [9:0]  page_ch1,
	input  wire logic [9:0]  page_ch2,
	input  wire logic [9:0]  page_ch3,
	output logic [7:0]       io_rdata,
	output logic [3:0]       dack,
	output logic [25:0]      mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic             io_rd_cmd,
	output logic             io_wr_cmd,
	output logic             tc_out,
	output logic             short_cycle_timing
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [7:0]           cmd_ff, nxt_cmd;
	logic [3:0]           mask_ff, nxt_mask;
	logic [3:0]           sreq_ff, nxt_sreq;
	logic [3:0]           tc_ff, nxt_tc;
	logic [7:0]           scratch_ff, nxt_scratch;
	logic                 ptr_ff, nxt_ptr;
	logic [7:0]           rdata_ff, nxt_rdata;
	fcd_pkg::fcd_state_e  state_ff, nxt_state;
	logic [1:0]           chan_ff, nxt_chan;
	logic [1:0]           wait_ff, nxt_wait;
	logic [3:0]           dack_ff, nxt_dack;
	logic [25:0]          maddr_ff, nxt_maddr;
	logic                 mrd_ff, nxt_mrd;
	logic                 mwr_ff, nxt_mwr;
	logic                 iord_ff, nxt_iord;
	logic                 iowr_ff, nxt_iowr;
	logic                 tco_ff, nxt_tco;
	logic                 short_ff, nxt_short;

	logic [15:0]          cur_addr_v [4];
	logic [15:0]          cur_cnt_v  [4];
	fcd_pkg::fcd_mode_t   mode_v     [4];
	logic [9:0]           page_v     [4];
	logic [3:0]           last_v;
	logic [3:0]           step_v;
	logic [3:0]           tc_set;
	logic [3:0]           req_v;
	logic [3:0]           cand;
	logic                 do_step;
	logic                 rd_status;
	logic                 ch_access;
	fcd_pkg::fcd_kind_e   kind;
	fcd_pkg::fcd_op_e     op;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// One-hot channel select, used for terminal count flags, steps and grants
	function automatic logic [3:0] chan_hot(input logic [1:0] sel);
		chan_hot = 4'h1 << sel;
	endfunction

	// Fixed priority, channel 0 highest
	function automatic logic [1:0] pick(input logic [3:0] c);
		pick = c[0] ? 2'h0 : c[1] ? 2'h1 : c[2] ? 2'h2 : 2'h3;
	endfunction

	// Polarity bit 6 exists for compatibility; the system expects it at zero
	assign req_v     = (dreq ^ {4{cmd_ff[`FCD_CMD_DREQ_LOW]}}) | sreq_ff;
	assign cand      = req_v & ~mask_ff;
	assign rd_status = io_rd && (io_addr == `FCD_PORT_STATUS);
	assign ch_access = (io_rd || io_wr) && !io_addr[3];
	assign kind      = fcd_pkg::fcd_kind_e'(mode_v[chan_ff][5:4]);
	assign op        = fcd_pkg::fcd_op_e'(mode_v[chan_ff][1:0]);
	assign page_v[0] = page_ch0;
	assign page_v[1] = page_ch1;
	assign page_v[2] = page_ch2;
	assign page_v[3] = page_ch3;

	// ****************************************************************
	// Channels
	// ****************************************************************
	for (genvar i = 0; i < 4; i++) begin : g_chan
		fcd_chan u_chan (
			.clk_sys   (clk_sys),
			.rst_n     (rst_n),
			.ce        (ce),
			.wr_addr   (io_wr && io_addr == {1'b0, 2'(i), 1'b0}),
			.wr_count  (io_wr && io_addr == {1'b0, 2'(i), 1'b1}),
			.byte_hi   (ptr_ff),
			.wdata     (io_wdata),
			.mode_wr   (io_wr && io_addr == `FCD_PORT_MODE && io_wdata[1:0] == 2'(i)),
			.mode_data (io_wdata[7:`FCD_MODE_FIELD_LSB]),
			.step      (step_v[i]),
			// Only channel 0 may hold, and only in memory copy mode
			.hold      ((i == 0) && cmd_ff[`FCD_CMD_MEM_COPY] && cmd_ff[`FCD_CMD_ADDR_HOLD]),
			.cur_addr  (cur_addr_v[i]),
			.cur_count (cur_cnt_v[i]),
			.mode      (mode_v[i]),
			.last      (last_v[i])
		);
	end

	// ****************************************************************
	// Transfer engine
	// ****************************************************************
	// Cascade channels only pass the grant through and never step
	always_comb begin
		nxt_state = state_ff;
		nxt_chan  = chan_ff;
		nxt_wait  = wait_ff;
		do_step   = 1'b0;
		tc_set    = 4'h0;
		case (state_ff)
			fcd_pkg::FCD_ST_IDLE: begin
				// A reloaded channel restarts here with no software action
				if (!cmd_ff[`FCD_CMD_DISABLE] && |cand) begin
					nxt_state = fcd_pkg::FCD_ST_XFER;
					nxt_chan  = pick(cand);
					nxt_wait  = cmd_ff[`FCD_CMD_SHORT_CYCLE] ? `FCD_CYC_SHORT - 2'h1
						: `FCD_CYC_NORMAL - 2'h1;
				end
			end
			fcd_pkg::FCD_ST_XFER: begin
				if (kind == fcd_pkg::FCD_KIND_CASCADE) begin
					if (!req_v[chan_ff]) begin
						nxt_state = fcd_pkg::FCD_ST_IDLE;
					end
				end else if (wait_ff != 2'h0) begin
					nxt_wait = wait_ff - 2'h1;
				end else begin
					do_step  = 1'b1;
					nxt_wait = cmd_ff[`FCD_CMD_SHORT_CYCLE] ? `FCD_CYC_SHORT - 2'h1
						: `FCD_CYC_NORMAL - 2'h1;
					if (last_v[chan_ff]) begin
						tc_set    = chan_hot(chan_ff);
						nxt_state = fcd_pkg::FCD_ST_IDLE;
					end else if (kind == fcd_pkg::FCD_KIND_SINGLE) begin
						nxt_state = fcd_pkg::FCD_ST_IDLE;
					end else if (kind == fcd_pkg::FCD_KIND_DEMAND && !req_v[chan_ff]) begin
						nxt_state = fcd_pkg::FCD_ST_IDLE;
					end
				end
			end
			default: begin
				nxt_state = fcd_pkg::FCD_ST_IDLE;
			end
		endcase
		// Master clear aborts any run in progress
		if (io_wr && io_addr == `FCD_PORT_MASTER_CLEAR) begin
			nxt_state = fcd_pkg::FCD_ST_IDLE;
		end
	end

	assign step_v = do_step ? chan_hot(chan_ff) : 4'h0;

	// ****************************************************************
	// Bus strobes, registered one cycle behind the engine state
	// ****************************************************************
	always_comb begin
		nxt_dack  = 4'h0;
		nxt_maddr = maddr_ff;
		nxt_mrd   = 1'b0;
		nxt_mwr   = 1'b0;
		nxt_iord  = 1'b0;
		nxt_iowr  = 1'b0;
		nxt_tco   = do_step && last_v[chan_ff];
		nxt_short = cmd_ff[`FCD_CMD_SHORT_CYCLE];
		if (state_ff == fcd_pkg::FCD_ST_XFER) begin
			nxt_dack = chan_hot(chan_ff);
			if (kind != fcd_pkg::FCD_KIND_CASCADE) begin
				nxt_maddr = {page_v[chan_ff], cur_addr_v[chan_ff]};
				// Verify and the reserved code sequence normally but strobe nothing
				nxt_mwr  = (op == fcd_pkg::FCD_OP_WRITE);
				nxt_iord = (op == fcd_pkg::FCD_OP_WRITE);
				nxt_mrd  = (op == fcd_pkg::FCD_OP_READ);
				nxt_iowr = (op == fcd_pkg::FCD_OP_READ);
			end
		end
		nxt_dack = nxt_dack ^ {4{!cmd_ff[`FCD_CMD_DACK_HIGH]}};
	end

	// ****************************************************************
	// Port decode, masks, status and read data
	// ****************************************************************
	always_comb begin
		nxt_cmd     = cmd_ff;
		nxt_mask    = mask_ff;
		nxt_sreq    = sreq_ff;
		nxt_scratch = scratch_ff;
		nxt_ptr     = ptr_ff;
		nxt_rdata   = rdata_ff;
		if (ch_access) begin
			nxt_ptr = !ptr_ff;
		end
		if (io_rd) begin
			case (io_addr)
				`FCD_PORT_STATUS:  nxt_rdata = {req_v, tc_ff};
				`FCD_PORT_SCRATCH: nxt_rdata = scratch_ff;
				4'h0, 4'h2, 4'h4, 4'h6: begin
					nxt_rdata = ptr_ff ? cur_addr_v[io_addr[2:1]][15:8]
						: cur_addr_v[io_addr[2:1]][7:0];
				end
				4'h1, 4'h3, 4'h5, 4'h7: begin
					nxt_rdata = ptr_ff ? cur_cnt_v[io_addr[2:1]][15:8]
						: cur_cnt_v[io_addr[2:1]][7:0];
				end
				default: nxt_rdata = 8'h00;
			endcase
		end
		if (io_wr) begin
			case (io_addr)
				`FCD_PORT_COMMAND: nxt_cmd = io_wdata;
				`FCD_PORT_SOFT_REQ: begin
					nxt_sreq[io_wdata[1:0]] = io_wdata[`FCD_MASK_VALUE_BIT];
				end
				`FCD_PORT_SINGLE_MASK: begin
					nxt_mask[io_wdata[1:0]] = io_wdata[`FCD_MASK_VALUE_BIT];
				end
				`FCD_PORT_PTR_CLEAR: nxt_ptr = 1'b0;
				`FCD_PORT_MASTER_CLEAR: begin
					nxt_cmd     = `FCD_RST_COMMAND;
					nxt_mask    = `FCD_RST_MASK;
					nxt_sreq    = 4'h0;
					nxt_scratch = 8'h00;
					nxt_ptr     = 1'b0;
				end
				`FCD_PORT_MASK_CLEAR: nxt_mask = 4'h0;
				`FCD_PORT_ALL_MASK:   nxt_mask = io_wdata[3:0];
				default: begin
				end
			endcase
		end
		// A finished run without reload masks itself; the hardware set wins
		for (int k = 0; k < 4; k++) begin
			if (tc_set[k] && !mode_v[k][2]) begin
				nxt_mask[k] = 1'b1;
			end
		end
		nxt_sreq = nxt_sreq & ~tc_set;
		// Status read clears counts, but a count reached now survives
		nxt_tc = (rd_status ? 4'h0 : tc_ff) | tc_set;
		if (io_wr && io_addr == `FCD_PORT_MASTER_CLEAR) begin
			nxt_tc = 4'h0;
		end
	end

	// All state, frozen while the clock enable is low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ff     <= `FCD_RST_COMMAND;
			mask_ff    <= `FCD_RST_MASK;
			sreq_ff    <= 4'h0;
			tc_ff      <= 4'h0;
			scratch_ff <= 8'h00;
			ptr_ff     <= 1'b0;
			rdata_ff   <= 8'h00;
			state_ff   <= fcd_pkg::FCD_ST_IDLE;
			chan_ff    <= 2'h0;
			wait_ff    <= 2'h0;
			dack_ff    <= `FCD_RST_DACK_IDLE;
			maddr_ff   <= 26'h0000000;
			mrd_ff     <= 1'b0;
			mwr_ff     <= 1'b0;
			iord_ff    <= 1'b0;
			iowr_ff    <= 1'b0;
			tco_ff     <= 1'b0;
			short_ff   <= 1'b0;
		end else if (ce) begin
			cmd_ff     <= nxt_cmd;
			mask_ff    <= nxt_mask;
			sreq_ff    <= nxt_sreq;
			tc_ff      <= nxt_tc;
			scratch_ff <= nxt_scratch;
			ptr_ff     <= nxt_ptr;
			rdata_ff   <= nxt_rdata;
			state_ff   <= nxt_state;
			chan_ff    <= nxt_chan;
			wait_ff    <= nxt_wait;
			dack_ff    <= nxt_dack;
			maddr_ff   <= nxt_maddr;
			mrd_ff     <= nxt_mrd;
			mwr_ff     <= nxt_mwr;
			iord_ff    <= nxt_iord;
			iowr_ff    <= nxt_iowr;
			tco_ff     <= nxt_tco;
			short_ff   <= nxt_short;
		end
	end

	assign io_rdata           = rdata_ff;
	assign dack               = dack_ff;
	assign mem_addr           = maddr_ff;
	assign mem_rd             = mrd_ff;
	assign mem_wr             = mwr_ff;
	assign io_rd_cmd          = iord_ff;
	assign io_wr_cmd          = iowr_ff;
	assign tc_out             = tco_ff;
	assign short_cycle_timing = short_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n || !ce);

	sequence seq_start;
		state_ff == fcd_pkg::FCD_ST_IDLE && nxt_state == fcd_pkg::FCD_ST_XFER;
	endsequence

	chk_all_mask_load: assert property (io_wr && io_addr == `FCD_PORT_ALL_MASK && !(|tc_set)
		|=> mask_ff == $past(io_wdata[3:0]))
		else $error("general mask not loaded");
	chk_one_mask_set: assert property (io_wr && io_addr == `FCD_PORT_SINGLE_MASK
		|=> mask_ff[$past(io_wdata[1:0])] == $past(io_wdata[2]) || $past(|tc_set))
		else $error("single mask not applied");
	chk_mask_clear: assert property (io_wr && io_addr == `FCD_PORT_MASK_CLEAR && !(|tc_set)
		|=> mask_ff == 4'h0)
		else $error("mask clear failed");
	chk_master_clr: assert property (io_wr && io_addr == `FCD_PORT_MASTER_CLEAR
		|=> mask_ff == 4'hF && cmd_ff == 8'h00 && !ptr_ff && tc_ff == 4'h0
		&& state_ff == fcd_pkg::FCD_ST_IDLE)
		else $error("master clear incomplete");
	chk_ptr_clear: assert property (io_wr && io_addr == `FCD_PORT_PTR_CLEAR |=> !ptr_ff)
		else $error("byte pointer not cleared");
	chk_status_read: assert property (rd_status
		|=> rdata_ff == {$past(req_v), $past(tc_ff)} && tc_ff == $past(tc_set))
		else $error("status read wrong or counts kept");
	chk_masked_idle: assert property (state_ff == fcd_pkg::FCD_ST_IDLE && cand == 4'h0
		|=> state_ff == fcd_pkg::FCD_ST_IDLE)
		else $error("masked request served");
	chk_start_timing: assert property (seq_start
		|=> wait_ff == (cmd_ff[`FCD_CMD_SHORT_CYCLE] ? 2'h0 : 2'h1) || !$stable(cmd_ff))
		else $error("cycle timing wrong");
	chk_verify_quiet: assert property (state_ff == fcd_pkg::FCD_ST_XFER
		&& op == fcd_pkg::FCD_OP_VERIFY |=> !mem_rd && !mem_wr && !io_rd_cmd && !io_wr_cmd)
		else $error("verify moved data");
	chk_write_strobe: assert property (state_ff == fcd_pkg::FCD_ST_XFER && kind !=
		fcd_pkg::FCD_KIND_CASCADE && op == fcd_pkg::FCD_OP_WRITE |=> mem_wr && io_rd_cmd)
		else $error("write transfer strobes missing");
	chk_single_ends: assert property (do_step && kind == fcd_pkg::FCD_KIND_SINGLE
		|=> state_ff == fcd_pkg::FCD_ST_IDLE)
		else $error("single transfer kept the bus");

endmodule

// File: tb/fcd_dev.sv
// Model of a requesting ISA I/O device on the channel request lines
module fcd_dev (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [3:0] go,
	input  wire logic [3:0] drop,
	input  wire logic [3:0] dack,
	output logic      [3:0] dreq
);
	timeunit 1ns;
	timeprecision 1ns;

	// Request active high, raised on go, dropped once the active-low grant is seen
	// A device that is never served may also withdraw its request on drop
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			dreq <= 4'h0;
		else
			dreq <= (dreq | go) & dack & ~drop;
	end
endmodule

// File: tb/fcd_top_bench.sv
// Self-checking bench for the four-channel DMA controller
`include "fcd_consts.svh"

module fcd_top_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  io_addr = 4'h0;
	logic [7:0]  io_wdata = 8'h00;
	logic        io_wr = 1'b0;
	logic        io_rd = 1'b0;
	logic [3:0]  go = 4'h0;
	logic [3:0]  drop = 4'h0;
	logic        ce = 1'b1;
	logic [3:0]  dreq;
	logic [9:0]  pg [4] = '{10'h3A1, 10'h15C, 10'h2E7, 10'h0B4};
	logic [7:0]  io_rdata;
	logic [3:0]  dack;
	logic [25:0] mem_addr;
	logic        mem_rd, mem_wr, io_rd_cmd, io_wr_cmd, tc_out, short_cycle_timing;
	int          mismatches = 0;
	int          check_count = 0;

	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;

	fcd_top fcd_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .dreq(dreq),
		.page_ch0(pg[0]), .page_ch1(pg[1]), .page_ch2(pg[2]), .page_ch3(pg[3]),
		.io_rdata(io_rdata), .dack(dack), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .io_rd_cmd(io_rd_cmd), .io_wr_cmd(io_wr_cmd), .tc_out(tc_out),
		.short_cycle_timing(short_cycle_timing));
	fcd_dev fcd_dev_i (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .drop(drop), .dack(dack),
		.dreq(dreq));

	task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One-cycle strobes, inputs change on the falling edge only
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk_sys) begin
			io_addr = a;
			io_wdata = d;
			io_wr = 1'b1;
		end
		@(negedge clk_sys) io_wr = 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk_sys) begin
			io_addr = a;
			io_rd = 1'b1;
		end
		@(negedge clk_sys) io_rd = 1'b0;
		chk(io_rdata, e);
	endtask

	// Request a channel and watch its grant: addresses, strobes, one TC, grant cycles
	task automatic run(input int ch, input logic [25:0] a0, a1, input logic erd, ewr,
		input int en);
		logic [25:0] f, l;
		logic [3:0]  s;
		int          n, t, tcs;
		n = 0;
		tcs = 0;
		s = 4'h0;
		@(negedge clk_sys) go = 4'(1 << ch);
		@(negedge clk_sys) go = 4'h0;
		for (t = 0; t < 80 && !(n > 0 && dack === 4'hF && tcs > 0); t++) begin
			@(negedge clk_sys);
			if (dack[ch] === 1'b0) begin
				if (n == 0)
					f = mem_addr;
				l = mem_addr;
				n++;
				// Each strobe of a pair is collected on its own
				s |= {mem_rd, io_wr_cmd, mem_wr, io_rd_cmd};
			end
			if (tc_out === 1'b1)
				tcs++;
		end
		if (t == 80) begin
			mismatches++;
			results();
		end
		chk(f, a0);
		chk(l, a1);
		chk({s, 8'(tcs), 8'(n)}, {erd, erd, ewr, ewr, 8'h01, 8'(en)});
	endtask

	// A masked request never reaches a grant; the device then withdraws it
	task automatic blocked(input int ch);
		logic [3:0] seen;
		seen = 4'hF;
		@(negedge clk_sys) go = 4'(1 << ch);
		@(negedge clk_sys) go = 4'h0;
		// Any grant in the window is caught, not only one still standing at its end
		repeat (10) begin
			@(negedge clk_sys);
			seen &= dack;
		end
		@(negedge clk_sys) drop = 4'(1 << ch);
		@(negedge clk_sys) drop = 4'h0;
		chk(seen, 4'hF);
	endtask

	task automatic t_reset();
		rd(`FCD_PORT_STATUS, 8'h00);
		chk(short_cycle_timing, 1'b0);
		blocked(0);
		$display("test reset done");
	endtask

	task automatic t_block();
		wr(4'h2, 8'h34);
		wr(`FCD_PORT_PTR_CLEAR, 8'h5A);
		wr(4'h2, 8'h34);
		wr(4'h2, 8'h12);
		wr(4'h3, 8'h01);
		wr(4'h3, 8'h00);
		wr(`FCD_PORT_MODE, 8'h85);
		wr(`FCD_PORT_SINGLE_MASK, 8'h01);
		run(1, {pg[1], 16'h1234}, {pg[1], 16'h1235}, 1'b0, 1'b1, 4);
		rd(`FCD_PORT_STATUS, 8'h02);
		rd(`FCD_PORT_STATUS, 8'h00);
		blocked(1);
		$display("test block done");
	endtask

	task automatic t_auto();
		wr(`FCD_PORT_PTR_CLEAR, 8'h00);
		wr(4'h4, 8'h10);
		wr(4'h4, 8'h00);
		wr(4'h5, 8'h01);
		wr(4'h5, 8'h00);
		wr(`FCD_PORT_MODE, 8'hBA);
		wr(`FCD_PORT_ALL_MASK, 8'h0B);
		run(2, {pg[2], 16'h0010}, {pg[2], 16'h000F}, 1'b1, 1'b0, 4);
		wr(`FCD_PORT_PTR_CLEAR, 8'h00);
		wr(4'h6, 8'h00);
		wr(4'h6, 8'h00);
		wr(4'h7, 8'h00);
		wr(4'h7, 8'h00);
		wr(`FCD_PORT_MODE, 8'h43);
		wr(`FCD_PORT_MASK_CLEAR, 8'h00);
		run(3, {pg[3], 16'h0000}, {pg[3], 16'h0000}, 1'b0, 1'b0, 2);
		run(2, {pg[2], 16'h0010}, {pg[2], 16'h000F}, 1'b1, 1'b0, 4);
		$display("test auto done");
	endtask

	// Compressed timing halves the grant; master clear undoes it; a frozen write is lost
	task automatic t_cmd();
		wr(`FCD_PORT_COMMAND, 8'h08);
		@(negedge clk_sys);
		chk(short_cycle_timing, 1'b1);
		run(2, {pg[2], 16'h0010}, {pg[2], 16'h000F}, 1'b1, 1'b0, 2);
		wr(`FCD_PORT_MASTER_CLEAR, 8'h00);
		@(negedge clk_sys);
		chk(short_cycle_timing, 1'b0);
		rd(`FCD_PORT_SCRATCH, 8'h00);
		@(negedge clk_sys) ce = 1'b0;
		wr(`FCD_PORT_MASK_CLEAR, 8'h00);
		ce = 1'b1;
		blocked(2);
		$display("test command done");
	endtask

	// Reset for two cycles, then the scenarios in turn
	initial begin
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		t_reset();
		t_block();
		t_auto();
		t_cmd();
		results();
	end
endmodule
